// ### hdl/trig_io_map.svh
// Purpose: register offsets, field positions, reset values and timing counts of the trigger block
// Assumes: 32-bit register bus, one aligned word per register
// Notes: definitions only
`ifndef TRIG_IO_MAP_SVH
`define TRIG_IO_MAP_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_PERIOD 8'h04
`define OFS_BCOUNT 8'h08
`define OFS_CYCLEN 8'h0c
`define OFS_SWTRIG 8'h10
`define OFS_STATUS 8'h14

// control field positions
`define CTRL_MODE_LSB 0
`define CTRL_SRC_LSB 2
`define CTRL_IN_NEG 4
`define CTRL_OUT_EN 5
`define CTRL_OUT_NEG 6
`define CTRL_NOISE 7

// reset values: sweep mode, internal source, rising edges, output off
`define CTRL_RST 8'h00
`define PERIOD_RST 24'h000064
`define BCOUNT_RST 16'h0001
`define CYCLEN_RST 16'h000a

// timing: clock period and least width of the bus-source pulse
`define CLK_PERIOD_NS 40
`define PULSE_MIN_NS 1000
`define PULSE_CYC ((`PULSE_MIN_NS / `CLK_PERIOD_NS) + 1)

`endif

// ### hdl/trig_io_pkg.sv
// Purpose: types shared by the trigger block
// Assumes: nothing
// Notes: codes follow declaration order, matching the control register fields
package trig_io_pkg;
    // operating modes
    typedef enum logic [1:0] {MODE_SWEEP, MODE_BURST, MODE_GATED, MODE_FSK} mode_t;
    // trigger sources
    typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_BUS, SRC_NONE} src_t;
    // engine states
    typedef enum logic {ST_IDLE, ST_RUN} eng_t;
endpackage

// ### hdl/level_sync.sv
// Purpose: two-stage synchroniser for asynchronous levels
// Assumes: synchronous active-low reset
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 1
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r; // first stage, read only by the second
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // next values: shift one stage per clock
    always_comb begin
        meta_nxt = d_in;
        q_nxt = meta_r;
    end

    // register both stages
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_out <= q_nxt;
        end
    end
endmodule

// ### hdl/trig_io.sv
// Purpose: trigger input and trigger output control for sweep, burst and keyed modes
// Assumes: AHB-Lite slave, zero wait states, OKAY always; one clock CLK at 25 MHz
// Notes: the shared connector is TRIG_I / TRIG_O / TRIG_OE
// Operation
// - external edge starts exactly one sweep
// - each accepted trigger gives burst count cycles
// - gated burst runs continuously while gate true
// - gate false finishes cycle, holds start phase
// - noise halts at once when gate false
// - enabled output edges at start, polarity selectable
// - internal source gives half-duty square per period in sweep and burst modes
// - external source forces trigger output off
// - bus source gives pulse over one microsecond
// - edges ignored while external burst runs
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "trig_io_map.svh"
module trig_io (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic TRIG_I,
    output logic TRIG_O,
    output logic TRIG_OE,
    output logic WAVE_RUN,
    output logic FSK_HOP,
    output logic SEQ_START,
    output trig_io_pkg::mode_t MODE
);
    import trig_io_pkg::*;

    // register file state
    logic [7:0] ctrl_r, ctrl_nxt; // mode, source, slopes, enables
    logic [23:0] period_r, period_nxt; // sweep time or burst period in clocks
    logic [15:0] bcount_r, bcount_nxt; // burst count in waveform cycles
    logic [15:0] cyclen_r, cyclen_nxt; // waveform cycle length in clocks
    logic swtrig_r, swtrig_nxt; // one-cycle bus trigger
    logic wr_pend_r, wr_pend_nxt; // write data phase pending
    logic [7:0] wr_addr_r, wr_addr_nxt; // address of pending write
    logic [31:0] hrdata_nxt;

    // decoded control fields
    mode_t mode;
    src_t src;
    logic in_neg, out_en, out_neg, noise;
    assign mode = mode_t'(ctrl_r[`CTRL_MODE_LSB +: 2]);
    assign src = src_t'(ctrl_r[`CTRL_SRC_LSB +: 2]);
    assign in_neg = ctrl_r[`CTRL_IN_NEG];
    assign out_en = ctrl_r[`CTRL_OUT_EN];
    assign out_neg = ctrl_r[`CTRL_OUT_NEG];
    assign noise = ctrl_r[`CTRL_NOISE];

    // trigger input path
    logic trig_lvl; // synchronised input level
    logic trig_prev_r, trig_prev_nxt; // previous level for edge detection
    level_sync #(.W(1)) u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .d_in(TRIG_I),
        .q_out(trig_lvl)
    );

    // engine state
    eng_t state_r, state_nxt;
    logic [23:0] per_cnt_r, per_cnt_nxt; // internal period counter
    logic [23:0] run_cnt_r, run_cnt_nxt; // clocks into current sweep
    logic [15:0] cyc_cnt_r, cyc_cnt_nxt; // clocks into current waveform cycle
    logic [15:0] cyc_left_r, cyc_left_nxt; // burst cycles remaining
    logic [5:0] pulse_r, pulse_nxt; // bus-source pulse width counter
    logic start, edge_hit, gate_true, cyc_end, sq_lvl, out_raw;
    logic run_last; // last clock of an internal run
    logic [23:0] per_len;
    logic [15:0] cyc_len;
    logic run_nxt, hop_nxt, trig_o_nxt, trig_oe_nxt;
    logic [31:0] status;

    assign status = {27'h0, trig_lvl, FSK_HOP, TRIG_O, WAVE_RUN, (state_r == ST_RUN)};

    // bus slave: capture address phase, write in data phase, register read data
    always_comb begin
        ctrl_nxt = ctrl_r;
        period_nxt = period_r;
        bcount_nxt = bcount_r;
        cyclen_nxt = cyclen_r;
        swtrig_nxt = 1'b0;
        wr_pend_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        hrdata_nxt = HRDATA;
        // data phase of a write
        if (wr_pend_r) begin
            unique case (wr_addr_r)
                `OFS_CTRL: ctrl_nxt = HWDATA[7:0];
                `OFS_PERIOD: period_nxt = HWDATA[23:0];
                `OFS_BCOUNT: bcount_nxt = HWDATA[15:0];
                `OFS_CYCLEN: cyclen_nxt = HWDATA[15:0];
                `OFS_SWTRIG: swtrig_nxt = HWDATA[0];
                default: ;
            endcase
        end
        // address phase
        if (HSEL && HTRANS[1] && HREADY) begin
            if (HWRITE) begin
                wr_pend_nxt = 1'b1;
                wr_addr_nxt = HADDR;
            end else begin
                unique case (HADDR)
                    `OFS_CTRL: hrdata_nxt = {24'h0, ctrl_r};
                    `OFS_PERIOD: hrdata_nxt = {8'h0, period_r};
                    `OFS_BCOUNT: hrdata_nxt = {16'h0, bcount_r};
                    `OFS_CYCLEN: hrdata_nxt = {16'h0, cyclen_r};
                    `OFS_STATUS: hrdata_nxt = status;
                    default: hrdata_nxt = 32'h0; // unmapped and write-only read zero
                endcase
            end
        end
    end

    // register the bus slave state
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_r <= `CTRL_RST;
            period_r <= `PERIOD_RST;
            bcount_r <= `BCOUNT_RST;
            cyclen_r <= `CYCLEN_RST;
            swtrig_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            HRDATA <= 32'h0;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            period_r <= period_nxt;
            bcount_r <= bcount_nxt;
            cyclen_r <= cyclen_nxt;
            swtrig_r <= swtrig_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            HRDATA <= hrdata_nxt;
            HREADYOUT <= 1'b1; // never stalls
            HRESP <= 1'b0; // always OKAY
        end
    end

    // engine: start decision, sweep and burst sequencing, trigger output
    always_comb begin
        per_len = (period_r == 24'h0) ? 24'h1 : period_r;
        cyc_len = (cyclen_r == 16'h0) ? 16'h1 : cyclen_r;
        trig_prev_nxt = trig_lvl;
        // selected edge on the synchronised input
        edge_hit = in_neg ? (trig_prev_r && !trig_lvl) : (!trig_prev_r && trig_lvl);
        gate_true = trig_lvl ^ in_neg; // gate polarity follows the slope setting
        cyc_end = (cyc_cnt_r == cyc_len - 16'h1);
        // free-running period counter only for the internal source in sweep and burst modes
        if (src == SRC_INT && (mode == MODE_SWEEP || mode == MODE_BURST)) begin
            per_cnt_nxt = (per_cnt_r >= per_len - 24'h1) ? 24'h0 : per_cnt_r + 24'h1;
        end else begin
            per_cnt_nxt = 24'h0;
        end
        // last clock of an internal run, so the next period starts with no gap
        run_last = (state_r == ST_RUN) && (src == SRC_INT) &&
            ((mode == MODE_SWEEP && run_cnt_r == per_len - 24'h1) ||
            (mode == MODE_BURST && cyc_end && cyc_left_r == 16'h1));
        // start from idle or on the last internal clock; edges during a run are dropped
        start = 1'b0;
        if ((state_r == ST_IDLE || run_last) && (mode == MODE_SWEEP || mode == MODE_BURST)) begin
            unique case (src)
                SRC_INT: start = (per_cnt_r == 24'h0);
                SRC_EXT: start = edge_hit;
                SRC_BUS: start = swtrig_r;
                default: start = 1'b0; // spare source code never starts
            endcase
        end
        state_nxt = state_r;
        run_cnt_nxt = run_cnt_r;
        cyc_cnt_nxt = cyc_cnt_r;
        cyc_left_nxt = cyc_left_r;
        unique case (state_r)
            ST_IDLE: begin
                cyc_cnt_nxt = 16'h0; // hold at starting phase
                run_cnt_nxt = 24'h0;
                if (start) begin
                    state_nxt = ST_RUN;
                    cyc_left_nxt = (bcount_r == 16'h0) ? 16'h1 : bcount_r;
                end else if (mode == MODE_GATED && gate_true) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                cyc_cnt_nxt = cyc_end ? 16'h0 : cyc_cnt_r + 16'h1;
                run_cnt_nxt = run_cnt_r + 24'h1;
                unique case (mode)
                    MODE_SWEEP: begin
                        // one sweep lasts the sweep time
                        if (run_cnt_r == per_len - 24'h1) begin
                            state_nxt = ST_IDLE;
                        end
                    end
                    MODE_BURST: begin
                        if (cyc_end) begin
                            cyc_left_nxt = cyc_left_r - 16'h1;
                            if (cyc_left_r == 16'h1) begin
                                state_nxt = ST_IDLE;
                            end
                        end
                    end
                    MODE_GATED: begin
                        if (!gate_true && noise) begin
                            state_nxt = ST_IDLE;
                            cyc_cnt_nxt = 16'h0;
                        end else if (!gate_true && cyc_end) begin
                            state_nxt = ST_IDLE;
                        end
                    end
                    MODE_FSK: state_nxt = ST_IDLE; // keying never runs the engine
                endcase
                // internal source: next run follows at once
                if (start) begin
                    state_nxt = ST_RUN;
                    run_cnt_nxt = 24'h0;
                    cyc_cnt_nxt = 16'h0;
                    cyc_left_nxt = (bcount_r == 16'h0) ? 16'h1 : bcount_r;
                end
            end
        endcase
        // bus-source pulse width
        if (start && src == SRC_BUS) begin
            pulse_nxt = 6'(`PULSE_CYC);
        end else if (pulse_r != 6'h0) begin
            pulse_nxt = pulse_r - 6'h1;
        end else begin
            pulse_nxt = 6'h0;
        end
        // square wave high for the first half of each period, rising with SEQ_START
        sq_lvl = (per_cnt_r < (per_len >> 1)) && (src == SRC_INT);
        out_raw = (src == SRC_INT) ? sq_lvl : (pulse_nxt != 6'h0);
        trig_oe_nxt = out_en && (src != SRC_EXT);
        trig_o_nxt = trig_oe_nxt ? (out_raw ^ out_neg) : 1'b0;
        run_nxt = (state_nxt == ST_RUN);
        hop_nxt = (mode == MODE_FSK) && trig_lvl;
    end

    // register the engine and the trigger, run, hop, start and mode outputs
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
            per_cnt_r <= 24'h0;
            run_cnt_r <= 24'h0;
            cyc_cnt_r <= 16'h0;
            cyc_left_r <= 16'h0;
            pulse_r <= 6'h0;
            trig_prev_r <= 1'b0;
            TRIG_O <= 1'b0;
            TRIG_OE <= 1'b0;
            WAVE_RUN <= 1'b0;
            FSK_HOP <= 1'b0;
            SEQ_START <= 1'b0;
            MODE <= MODE_SWEEP;
        end else begin
            state_r <= state_nxt;
            per_cnt_r <= per_cnt_nxt;
            run_cnt_r <= run_cnt_nxt;
            cyc_cnt_r <= cyc_cnt_nxt;
            cyc_left_r <= cyc_left_nxt;
            pulse_r <= pulse_nxt;
            trig_prev_r <= trig_prev_nxt;
            TRIG_O <= trig_o_nxt;
            TRIG_OE <= trig_oe_nxt;
            WAVE_RUN <= run_nxt;
            FSK_HOP <= hop_nxt;
            SEQ_START <= start; // marks each sweep or burst start
            MODE <= mode;
        end
    end
endmodule

// ### verification/trig_io_props.sv
// Purpose: port-level checker for trig_io
// Assumes: one clock CLK, synchronous active-low RST_N
// Notes: bound to trig_io below the module
`timescale 1ns/1ps
module trig_io_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TRIG_I,
    input wire logic TRIG_O,
    input wire logic TRIG_OE,
    input wire logic WAVE_RUN,
    input wire logic FSK_HOP,
    input wire logic SEQ_START,
    input wire trig_io_pkg::mode_t MODE
);
    import trig_io_pkg::*;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // keying level held high for five samples
    sequence key_hi;
        (MODE == MODE_FSK && TRIG_I) [*5];
    endsequence
    // keying level held low for five samples
    sequence key_lo;
        (MODE == MODE_FSK && !TRIG_I) [*5];
    endsequence
    // a triggered run opening
    sequence run_open;
        $rose(WAVE_RUN) && MODE != MODE_GATED;
    endsequence
    AST_START_RUN: assert property (SEQ_START |-> WAVE_RUN)
        else $error("start pulse without a run");
    AST_ONE_START: assert property (SEQ_START |=> !SEQ_START)
        else $error("start pulse longer than one cycle");
    AST_RUN_BEGIN: assert property (run_open |-> SEQ_START)
        else $error("run began without a start pulse");
    AST_OE_OFF: assert property (!TRIG_OE |-> !TRIG_O)
        else $error("trigger out level while not driving");
    AST_HOP_HI: assert property (key_hi |-> FSK_HOP)
        else $error("hop not selected for high key");
    AST_HOP_LO: assert property (key_lo |-> !FSK_HOP)
        else $error("carrier not selected for low key");
    AST_SYNC: assert property (MODE == MODE_FSK && $changed(TRIG_I) |-> ##2 $stable(FSK_HOP))
        else $error("key reached output without synchronising");
    AST_GATE_NOSTART: assert property (MODE == MODE_GATED && $past(MODE) == MODE_GATED |-> !SEQ_START)
        else $error("start pulse in gated mode");
endmodule
bind trig_io trig_io_props trig_io_props_i (.CLK(CLK), .RST_N(RST_N), .TRIG_I(TRIG_I), .TRIG_O(TRIG_O),
    .TRIG_OE(TRIG_OE), .WAVE_RUN(WAVE_RUN), .FSK_HOP(FSK_HOP), .SEQ_START(SEQ_START), .MODE(MODE));

// ### verification/ttl_trig_src.sv
// Purpose: model of the external ttl source on the trigger connector
// Assumes: the bench asks for a level on want
// Notes: edges land 7 ns after a clock edge, unrelated to sampling
`timescale 1ns/1ps
module ttl_trig_src (
    input wire logic CLK,
    input wire logic want,
    output logic lvl
);
    int gap = 0; // cycles since the last edge
    initial lvl = 1'b0;
    // follow the asked level, never toggling faster than 1 MHz
    always @(posedge CLK) begin
        gap++;
        if (want !== lvl && gap >= 13) begin
            gap = 0;
            lvl <= #7 want;
        end
    end
endmodule

// ### verification/trig_io_test.sv
// Purpose: self-checking bench for trig_io
// Assumes: zero-wait AHB-Lite slave, ttl source on the connector
// Notes: expected reads and run lengths are queued, compared at falling edges
`timescale 1ns/1ps
`include "trig_io_map.svh"
module trig_io_test;
    import trig_io_pkg::*;
    logic CLK = 0;
    logic RST_N = 0;
    logic [7:0] HADDR = 0;
    logic [1:0] HTRANS = 0;
    logic HWRITE = 0;
    logic [31:0] HWDATA = 0;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, TRIG_I, TRIG_O, TRIG_OE, WAVE_RUN, FSK_HOP, SEQ_START, ext_lvl;
    mode_t MODE;
    logic want = 0; // level asked of the source
    logic watch = 0; // run lengths are checked
    logic dph = 0; // read data phase in progress
    logic [63:0] q; // mask and expected read data
    logic [63:0] rdq[$];
    int runq[$]; // expected run lengths
    int err_count = 0, num_checks = 0, run_n = 0, seed = 32'h7a7f, b, c, n, h;
    always #20 CLK = ~CLK;
    // connector level: the block wins while it drives
    assign TRIG_I = TRIG_OE ? TRIG_O : ext_lvl;
    trig_io trig_io_i (.CLK(CLK), .RST_N(RST_N), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .TRIG_I(TRIG_I), .TRIG_O(TRIG_O), .TRIG_OE(TRIG_OE), .WAVE_RUN(WAVE_RUN),
        .FSK_HOP(FSK_HOP), .SEQ_START(SEQ_START), .MODE(MODE));
    ttl_trig_src ttl_trig_src_i (.CLK(CLK), .want(want), .lvl(ext_lvl));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(posedge CLK);
    endtask
    // one single transfer: address phase, then data phase
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        HADDR <= a;
        HWRITE <= w;
        HTRANS <= 2'b10;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rdq.push_back({m, e});
        xfer(1'b0, a, 32'h0);
    endtask
    // wait for the running waveform to stop
    task idle;
        n = 0;
        while (WAVE_RUN !== 1'b0 && n < 600) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 600) begin
            err_count++;
            $display("Error at %0t: run never stopped", $time);
        end
        cyc(2);
    endtask
    // width in cycles of the next pulse at the active level
    task pulse(input logic p);
        n = 0;
        h = 0;
        while (TRIG_O !== ~p && n < 60) begin
            @(negedge CLK);
            n++;
        end
        while (TRIG_O === ~p && h < 200) begin
            @(negedge CLK);
            h++;
        end
    endtask
    // monitor: read data and finished runs against the oldest note
    always @(negedge CLK) begin
        if (dph) begin
            q = rdq.pop_front();
            chk(HRDATA & q[63:32], q[31:0]);
            chk(HRESP, 1'b0);
        end
        dph = HTRANS[1] && !HWRITE;
        if (WAVE_RUN === 1'b1) begin
            run_n++;
        end else if (run_n > 0) begin
            if (watch) begin
                chk(run_n, (runq.size() > 0) ? runq.pop_front() : 0);
            end
            run_n = 0;
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge CLK);
        RST_N <= 1;
        rd(`OFS_CTRL, `CTRL_RST, 32'hff);
        rd(`OFS_PERIOD, `PERIOD_RST, 32'hffffff);
        rd(`OFS_BCOUNT, `BCOUNT_RST, 32'hffff);
        wr(8'h20, $random(seed));
        rd(8'h20, 32'h0, 32'hffffffff);
        wr(`OFS_CTRL, 32'h0c);
        idle;
        watch = 1;
        wr(`OFS_PERIOD, 32'd40);
        // external sweep on either edge; the other edge, arriving inside the run, starts nothing
        for (int neg = 0; neg < 2; neg++) begin
            wr(`OFS_CTRL, 32'h0c);
            want <= neg[0];
            cyc(20);
            wr(`OFS_CTRL, 32'h24 | (neg << 4));
            runq.push_back(40);
            want <= !neg[0];
            cyc(15);
            rd(`OFS_STATUS, 32'h3, 32'h7);
            chk(TRIG_OE, 0);
            want <= neg[0];
            idle;
        end
        // external burst of random size, retriggered inside the run
        b = 4 + ($random(seed) & 3);
        c = 10 + ($random(seed) & 7);
        wr(`OFS_BCOUNT, b);
        wr(`OFS_CYCLEN, c);
        wr(`OFS_CTRL, 32'h05);
        want <= 0;
        cyc(20);
        runq.push_back(b * c);
        want <= 1;
        cyc(15);
        want <= 0;
        cyc(15);
        want <= 1;
        cyc(15);
        want <= 0;
        idle;
        // keyed frequency shift
        wr(`OFS_CTRL, 32'h07);
        want <= 1;
        cyc(20);
        rd(`OFS_STATUS, 32'h8, 32'h8);
        chk(MODE, MODE_FSK);
        want <= 0;
        cyc(20);
        rd(`OFS_STATUS, 32'h0, 32'h8);
        // gated burst ends on a whole cycle, noise ends at once
        wr(`OFS_CYCLEN, 32'd10);
        for (int nz = 0; nz < 2; nz++) begin
            wr(`OFS_CTRL, 32'h06 | (nz << 7));
            runq.push_back(nz ? 35 : 40);
            want <= 1;
            cyc(35);
            want <= 0;
            idle;
        end
        // bus trigger pulse at both output polarities
        wr(`OFS_BCOUNT, 32'd1);
        for (int pol = 0; pol < 2; pol++) begin
            wr(`OFS_CTRL, 32'h29 | (pol << 6));
            cyc(2);
            runq.push_back(10);
            fork
                pulse(pol[0]);
                wr(`OFS_SWTRIG, 32'h1);
            join
            chk(h >= 26, 1);
            chk({TRIG_OE, TRIG_O}, {1'b1, pol[0]});
            idle;
        end
        // internal source: half-duty square over each sweep
        watch = 0;
        wr(`OFS_PERIOD, 32'd20);
        wr(`OFS_CTRL, 32'h20);
        n = 0;
        @(negedge CLK);
        while (SEQ_START !== 1'b1 && n < 200) begin
            @(negedge CLK);
            n++;
        end
        chk(TRIG_O, 1'b1);
        n = 0;
        h = 0;
        do begin
            h += (TRIG_O === 1'b1);
            n++;
            @(negedge CLK);
        end while (SEQ_START !== 1'b1 && n < 100);
        chk(n, 20);
        chk(h, 10);
        test_done;
    end
    // watchdog
    initial begin
        #400000;
        err_count++;
        $display("Error at %0t: timeout", $time);
        test_done;
    end
endmodule
